// [rtl/metering_regs.svh]
`ifndef METERING_REGS_SVH
`define METERING_REGS_SVH

// register indices; byte address is four times the index
`define IDX_CMP_LEVEL 8'h8d
`define IDX_SAG_ZX 8'h8e
`define IDX_SAG_LINE 8'h8f
`define IDX_PHCAL 8'h90
`define IDX_RMS_GAIN 8'h91
`define IDX_RMS_OFFSET 8'h92
`define IDX_ADC_EN 8'h93
`define IDX_TPS 8'h94
`define IDX_USER_CONFIG_SELECT_ONE 8'h96
`define IDX_USER_CONFIG_SELECT_TWO 8'h97
`define IDX_USER_CONFIG_SELECT_THREE 8'h98
`define IDX_IRQ_STATUS 8'h99
`define IDX_INTERRUPT_GATE_LINE_ONE 8'h9a
`define IDX_INTERRUPT_GATE_LINE_TWO 8'h9b
`define IDX_ENG_CLR 8'h9d
`define IDX_WRPROT 8'h9e
`define IDX_SOFT_RESET 8'h9f

// reset values
`define RST_CMP_LEVEL 24'hffffff
`define RST_SAG_ZX 24'h04ffff
`define RST_SAG_LINE 24'h100009
`define RST_PHCAL 24'h000000
`define RST_RMS_GAIN 16'h0000
`define RST_RMS_OFFSET 24'h000000
`define RST_ADC_EN 11'h000
`define RST_TPS 16'h07ff
`define RST_MODE 24'h000000
`define RST_MASK 24'h000000
`define ENERGY_CLEAR_SETTING_CLR 24'h000000
`define RST_WRPROT 16'h0000

// field positions
`define SAG_CYC_MSB 23
`define SAG_CYC_LSB 16
`define ZX_TOUT_MSB 15
`define ZX_TOUT_LSB 0
`define SAG_LVL_MSB 23
`define SAG_LVL_LSB 12
`define LINE_CYC_MSB 11
`define LINE_CYC_LSB 0
`define USER_CONFIG_SELECT_THREE_NEUTRAL_SRC_BIT 4
`define TPS_OFF_BIT 15
`define PH_BAND_EN_BIT 7

// interrupt status bit positions
`define IRQ_NEUTRAL_CMP 0
`define IRQ_SAG 1
`define IRQ_ZX_TOUT 2
`define IRQ_LINE_ENERGY 3
`define IRQ_BITS 4

// soft reset command codes
`define SR_FULL_CODE 24'h5a5a5a
`define SR_USER_CODE 24'h55aa55

// timing
`define CLK_PERIOD_NS 10
`define PHASE_STEP_NS 280
`define PHASE_STEP_MAX 7'h7d

`endif

// [rtl/metering_pkg.sv]
package metering_pkg;

  typedef struct packed {
    logic [23:0] cmp_level;
    logic [23:0] sag_zx;
    logic [23:0] sag_line;
    logic [23:0] phcal;
    logic [15:0] rms_gain;
    logic [23:0] rms_offset;
    logic [10:0] adc_en;
    logic [15:0] tps;
    logic [23:0] user_config_select_one;
    logic [23:0] user_config_select_two;
    logic [23:0] user_config_select_three;
    logic [23:0] interrupt_gate_line_one;
    logic [23:0] interrupt_gate_line_two;
    logic [23:0] eng_clr;
    logic [15:0] wrprot;
  } cfg_regs_s;

  typedef struct packed {
    logic [23:0] summed_current_rms;
    logic [23:0] neutral_current_rms;
    logic [11:0] voltage_magnitude;
    logic line_cycle;
    logic zero_cross;
    logic zx_tick;
  } meter_inputs_s;

  typedef enum logic [1:0] {
    BAND_NONE,
    BAND_LOW,
    BAND_MID,
    BAND_HIGH
  } phase_band_e;

endpackage

// [rtl/metering_threshold_control_regs.sv]
// Operation
// - the compare flag is 0 while the selected neutral rms is below the level, else 1.
// - mode three bit 4 picks summed-current rms (0) or measured neutral rms (1).
// - the sag duration in line cycles sits in bits 23:16 of the sag/timeout register, reset 4.
// - voltage below the 12-bit sag level (reset 0x100) longer than the duration raises sag.
// - the line energy period is the programmed 12-bit count plus one line cycles.
// - between the lower limit and the first breakpoint bits 7:0 apply, bit 7 enables.
// - one step is 280 ns (0.005 degrees) and the correction is clamped to 125 steps.
// - between the first and second breakpoints bits 15:8 apply, bit 15 enables.
// - between the second breakpoint and the upper limit bits 23:16 apply, bit 23 enables.
// - a 16-bit gain and a 24-bit offset for summed-current rms both reset to zero.
// - each converter channel has its own enable bit: 2..5 currents, 8..10 voltages.
// - temperature sensing is off when control bit 15 is 1, on when 0, on by default.
// - mask one gates sources onto interrupt one and mask two onto interrupt two.
// - writing 0x5a5a5a resets all state machines and registers.
// - writing 0x55aa55 returns the user read/write registers to their defaults.
`timescale 1ns/1ns
`default_nettype none
`include "metering_regs.svh"

module metering_threshold_control_regs
  import metering_pkg::*;
#(
  parameter logic [23:0] BAND_LOWER = 24'h000100,
  parameter logic [23:0] BAND_BP1 = 24'h010000,
  parameter logic [23:0] BAND_BP2 = 24'h100000,
  parameter logic [23:0] BAND_UPPER = 24'hfff000
)
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire meter_inputs_s meas_i,
  output cfg_regs_s cfg_o,
  output logic neutral_compare_flag_o,
  output logic [11:0] phase_delay_cycles_o,
  output logic temp_sensor_off_o,
  output logic interrupt_output_one_o,
  output logic interrupt_output_two_o
);

  localparam int unsigned STEP_CYC = `PHASE_STEP_NS / `CLK_PERIOD_NS;

  localparam cfg_regs_s CFG_DEFAULT = {`RST_CMP_LEVEL, `RST_SAG_ZX, `RST_SAG_LINE, `RST_PHCAL,
    `RST_RMS_GAIN, `RST_RMS_OFFSET, `RST_ADC_EN, `RST_TPS, `RST_MODE, `RST_MODE, `RST_MODE,
    `RST_MASK, `RST_MASK, `ENERGY_CLEAR_SETTING_CLR, `RST_WRPROT};

  // byte-lane merge of write data into an old register value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] upd(input logic [31:0] old_v);
    return lane_merge(old_v, avs_writedata_i, avs_byteenable_i);
  endfunction

  cfg_regs_s cfg_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic sr_full_r;
  logic sr_user_r;
  logic cmp_flag_r;
  logic [`IRQ_BITS-1:0] status_r;
  logic [`IRQ_BITS-1:0] status_nxt;
  logic [`IRQ_BITS-1:0] events;
  logic interrupt_output_one_r;
  logic interrupt_output_two_r;
  logic all_below_r;
  logic [8:0] sag_cnt_r;
  logic [15:0] zx_cnt_r;
  logic zx_fired_r;
  logic [11:0] line_cnt_r;
  logic [11:0] phase_delay_r;
  logic wr_fire;
  logic [7:0] idx;
  logic [31:0] wmerge;
  logic [23:0] sel_rms;
  logic sag_evt;
  logic zx_evt;
  logic line_evt;
  logic state_clr;
  phase_band_e band;
  logic [7:0] band_field;
  logic [6:0] band_steps;

  assign idx = avs_address_i[9:2];
  assign wr_fire = avs_write_i && !wait_r;
  assign wmerge = lane_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
  assign state_clr = sr_full_r;

  // bus handshake: waitrequest drops for one cycle, one edge after the request
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wait_r <= 1'b1;
    end
    else
    begin
      wait_r <= !((avs_read_i || avs_write_i) && wait_r);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (avs_read_i && wait_r)
    begin
      case (idx)
        `IDX_CMP_LEVEL: rdata_r <= {8'h00, cfg_r.cmp_level};
        `IDX_SAG_ZX: rdata_r <= {8'h00, cfg_r.sag_zx};
        `IDX_SAG_LINE: rdata_r <= {8'h00, cfg_r.sag_line};
        `IDX_PHCAL: rdata_r <= {8'h00, cfg_r.phcal};
        `IDX_RMS_GAIN: rdata_r <= {16'h0000, cfg_r.rms_gain};
        `IDX_RMS_OFFSET: rdata_r <= {8'h00, cfg_r.rms_offset};
        `IDX_ADC_EN: rdata_r <= {21'h000000, cfg_r.adc_en};
        `IDX_TPS: rdata_r <= {16'h0000, cfg_r.tps};
        `IDX_USER_CONFIG_SELECT_ONE: rdata_r <= {8'h00, cfg_r.user_config_select_one};
        `IDX_USER_CONFIG_SELECT_TWO: rdata_r <= {8'h00, cfg_r.user_config_select_two};
        `IDX_USER_CONFIG_SELECT_THREE: rdata_r <= {8'h00, cfg_r.user_config_select_three};
        `IDX_IRQ_STATUS: rdata_r <= {28'h0000000, status_r};
        `IDX_INTERRUPT_GATE_LINE_ONE: rdata_r <= {8'h00, cfg_r.interrupt_gate_line_one};
        `IDX_INTERRUPT_GATE_LINE_TWO: rdata_r <= {8'h00, cfg_r.interrupt_gate_line_two};
        `IDX_ENG_CLR: rdata_r <= {8'h00, cfg_r.eng_clr};
        `IDX_WRPROT: rdata_r <= {16'h0000, cfg_r.wrprot};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // soft reset commands take effect on the edge after the accepted write
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sr_full_r <= 1'b0;
      sr_user_r <= 1'b0;
    end
    else
    begin
      sr_full_r <= wr_fire && idx == `IDX_SOFT_RESET
                   && wmerge[23:0] == `SR_FULL_CODE;
      sr_user_r <= wr_fire && idx == `IDX_SOFT_RESET
                   && wmerge[23:0] == `SR_USER_CODE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cfg_r <= CFG_DEFAULT;
    end
    else if (sr_full_r || sr_user_r)
    begin
      cfg_r <= CFG_DEFAULT;
    end
    else if (wr_fire)
    begin
      case (idx)
        `IDX_CMP_LEVEL: cfg_r.cmp_level <= 24'(upd({8'h00, cfg_r.cmp_level}));
        `IDX_SAG_ZX: cfg_r.sag_zx <= 24'(upd({8'h00, cfg_r.sag_zx}));
        `IDX_SAG_LINE: cfg_r.sag_line <= 24'(upd({8'h00, cfg_r.sag_line}));
        `IDX_PHCAL: cfg_r.phcal <= 24'(upd({8'h00, cfg_r.phcal}));
        `IDX_RMS_GAIN: cfg_r.rms_gain <= 16'(upd({16'h0000, cfg_r.rms_gain}));
        `IDX_RMS_OFFSET: cfg_r.rms_offset <= 24'(upd({8'h00, cfg_r.rms_offset}));
        `IDX_ADC_EN: cfg_r.adc_en <= 11'(upd({21'h000000, cfg_r.adc_en}));
        `IDX_TPS: cfg_r.tps <= 16'(upd({16'h0000, cfg_r.tps}));
        `IDX_USER_CONFIG_SELECT_ONE: cfg_r.user_config_select_one <= 24'(upd({8'h00, cfg_r.user_config_select_one}));
        `IDX_USER_CONFIG_SELECT_TWO: cfg_r.user_config_select_two <= 24'(upd({8'h00, cfg_r.user_config_select_two}));
        `IDX_USER_CONFIG_SELECT_THREE: cfg_r.user_config_select_three <= 24'(upd({8'h00, cfg_r.user_config_select_three}));
        `IDX_INTERRUPT_GATE_LINE_ONE: cfg_r.interrupt_gate_line_one <= 24'(upd({8'h00, cfg_r.interrupt_gate_line_one}));
        `IDX_INTERRUPT_GATE_LINE_TWO: cfg_r.interrupt_gate_line_two <= 24'(upd({8'h00, cfg_r.interrupt_gate_line_two}));
        `IDX_ENG_CLR: cfg_r.eng_clr <= 24'(upd({8'h00, cfg_r.eng_clr}));
        `IDX_WRPROT: cfg_r.wrprot <= 16'(upd({16'h0000, cfg_r.wrprot}));
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  // neutral source select and threshold compare
  assign sel_rms = cfg_r.user_config_select_three[`USER_CONFIG_SELECT_THREE_NEUTRAL_SRC_BIT] ? meas_i.neutral_current_rms
                                                       : meas_i.summed_current_rms;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cmp_flag_r <= 1'b0;
    end
    else
    begin
      cmp_flag_r <= !state_clr && (sel_rms >= cfg_r.cmp_level);
    end
  end

  // sag: count whole line cycles spent below the level
  assign sag_evt = meas_i.line_cycle && all_below_r
                   && !(meas_i.voltage_magnitude >= cfg_r.sag_line[`SAG_LVL_MSB:`SAG_LVL_LSB])
                   && sag_cnt_r == {1'b0, cfg_r.sag_zx[`SAG_CYC_MSB:`SAG_CYC_LSB]};

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      all_below_r <= 1'b1;
      sag_cnt_r <= 9'h000;
    end
    else if (state_clr)
    begin
      all_below_r <= 1'b1;
      sag_cnt_r <= 9'h000;
    end
    else if (meas_i.line_cycle)
    begin
      all_below_r <= 1'b1;
      if (all_below_r
          && meas_i.voltage_magnitude < cfg_r.sag_line[`SAG_LVL_MSB:`SAG_LVL_LSB])
      begin
        if (sag_cnt_r != 9'h1ff)
        begin
          sag_cnt_r <= sag_cnt_r + 9'h001;
        end
      end
      else
      begin
        sag_cnt_r <= 9'h000;
      end
    end
    else if (meas_i.voltage_magnitude >= cfg_r.sag_line[`SAG_LVL_MSB:`SAG_LVL_LSB])
    begin
      all_below_r <= 1'b0;
    end
  end

  // zero-crossing timeout in ticks, fires once per silent stretch
  assign zx_evt = meas_i.zx_tick && !meas_i.zero_cross && !zx_fired_r
                  && zx_cnt_r == cfg_r.sag_zx[`ZX_TOUT_MSB:`ZX_TOUT_LSB];

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      zx_cnt_r <= 16'h0000;
      zx_fired_r <= 1'b0;
    end
    else if (state_clr || meas_i.zero_cross)
    begin
      zx_cnt_r <= 16'h0000;
      zx_fired_r <= 1'b0;
    end
    else if (meas_i.zx_tick)
    begin
      if (zx_evt)
      begin
        zx_fired_r <= 1'b1;
      end
      else if (zx_cnt_r != 16'hffff)
      begin
        zx_cnt_r <= zx_cnt_r + 16'h0001;
      end
    end
  end

  // line energy period counter
  assign line_evt = meas_i.line_cycle
                    && line_cnt_r == cfg_r.sag_line[`LINE_CYC_MSB:`LINE_CYC_LSB];

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      line_cnt_r <= 12'h000;
    end
    else if (state_clr || meas_i.line_cycle)
    begin
      line_cnt_r <= (state_clr || line_evt) ? 12'h000 : line_cnt_r + 12'h001;
    end
  end

  // phase correction band select
  always_comb
  begin
    band = BAND_NONE;
    band_field = 8'h00;
    if (sel_rms > BAND_LOWER && sel_rms < BAND_BP1)
    begin
      band = BAND_LOW;
    end
    else if (sel_rms >= BAND_BP1 && sel_rms < BAND_BP2)
    begin
      band = BAND_MID;
    end
    else if (sel_rms >= BAND_BP2 && sel_rms < BAND_UPPER)
    begin
      band = BAND_HIGH;
    end
    unique case (band)
      BAND_NONE: band_field = 8'h00;
      BAND_LOW: band_field = cfg_r.phcal[7:0];
      BAND_MID: band_field = cfg_r.phcal[15:8];
      BAND_HIGH: band_field = cfg_r.phcal[23:16];
    endcase
  end

  assign band_steps = (band_field[6:0] > `PHASE_STEP_MAX) ? `PHASE_STEP_MAX
                                                          : band_field[6:0];

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_delay_r <= 12'h000;
    end
    else
    begin
      phase_delay_r <= band_field[`PH_BAND_EN_BIT] ? 12'(band_steps) * 12'(STEP_CYC)
                                                   : 12'h000;
    end
  end

  // sticky status, write one to clear, a new event wins over the clear
  always_comb
  begin
    events = '0;
    events[`IRQ_NEUTRAL_CMP] = cmp_flag_r;
    events[`IRQ_SAG] = sag_evt;
    events[`IRQ_ZX_TOUT] = zx_evt;
    events[`IRQ_LINE_ENERGY] = line_evt;
    status_nxt = status_r;
    if (wr_fire && idx == `IDX_IRQ_STATUS)
    begin
      status_nxt = status_r & ~wmerge[`IRQ_BITS-1:0];
    end
    status_nxt = status_nxt | events;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      status_r <= '0;
    end
    else
    begin
      status_r <= state_clr ? '0 : status_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      interrupt_output_one_r <= 1'b0;
      interrupt_output_two_r <= 1'b0;
    end
    else
    begin
      interrupt_output_one_r <= |(status_r & cfg_r.interrupt_gate_line_one[`IRQ_BITS-1:0]);
      interrupt_output_two_r <= |(status_r & cfg_r.interrupt_gate_line_two[`IRQ_BITS-1:0]);
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign cfg_o = cfg_r;
  assign neutral_compare_flag_o = cmp_flag_r;
  assign phase_delay_cycles_o = phase_delay_r;
  assign temp_sensor_off_o = cfg_r.tps[`TPS_OFF_BIT];
  assign interrupt_output_one_o = interrupt_output_one_r;
  assign interrupt_output_two_o = interrupt_output_two_r;

endmodule

`default_nettype wire

// [bench/regs_checker.sv]
`timescale 1ns/1ns
`default_nettype none
`include "metering_regs.svh"
module regs_checker
  import metering_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire meter_inputs_s meas_i,
  input wire cfg_regs_s cfg_o,
  input wire logic neutral_compare_flag_o,
  input wire logic [11:0] phase_delay_cycles_o,
  input wire logic temp_sensor_off_o,
  input wire logic interrupt_output_one_o,
  input wire logic interrupt_output_two_o
);
  cfg_regs_s dflt;
  logic sr_wr;
  logic sr_full;
  logic [23:0] sel;
  logic [23:0] code;
  assign dflt = {24'hffffff, 24'h04ffff, 24'h100009, 24'h000000, 16'h0000, 24'h000000,
    11'h000, 16'h07ff, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
    16'h0000};
  assign sr_wr = avs_write_i && !avs_waitrequest_o && avs_address_i[9:2] == 8'h9f;
  assign code = avs_writedata_i[23:0];
  assign sr_full = sr_wr && code == 24'h5a5a5a;
  // selected source for the neutral comparison
  assign sel = cfg_o.user_config_select_three[4] ? meas_i.neutral_current_rms : meas_i.summed_current_rms;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  reset_defaults_a: assert property (!$past(resetn_i) |-> cfg_o == dflt)
    else $error("config differs from defaults after reset");
  compare_flag_a: assert property ($past(resetn_i) && !$past(sr_full, 2) |->
    neutral_compare_flag_o == ($past(sel) >= $past(cfg_o.cmp_level)))
    else $error("compare flag wrong");
  full_reset_a: assert property (sr_full |-> ##2
    cfg_o == dflt && !neutral_compare_flag_o)
    else $error("full soft reset did not clear state");
  user_reset_a: assert property (sr_wr && code == 24'h55aa55 |-> ##2 cfg_o == dflt)
    else $error("user soft reset did not restore config");
  bad_code_a: assert property (sr_wr && code != 24'h5a5a5a && code != 24'h55aa55
    |-> ##2 $stable(cfg_o))
    else $error("unknown soft reset code changed config");
  wait_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  temp_switch_a: assert property ($stable(cfg_o.tps[15]) |->
    temp_sensor_off_o == cfg_o.tps[15])
    else $error("temperature switch does not follow control bit");
  phase_range_a: assert property (phase_delay_cycles_o <= 12'hdac &&
    phase_delay_cycles_o % 28 == 0)
    else $error("phase delay outside step grid or range");
  irq_one_gate_a: assert property (interrupt_output_one_o |-> $past(|cfg_o.interrupt_gate_line_one[3:0]))
    else $error("interrupt one raised with mask one closed");
  irq_two_gate_a: assert property (interrupt_output_two_o |-> $past(|cfg_o.interrupt_gate_line_two[3:0]))
    else $error("interrupt two raised with mask two closed");
  cover property ($rose(neutral_compare_flag_o));
  cover property ($rose(interrupt_output_one_o));
  cover property (sr_wr && code == 24'h5a5a5a);
endmodule
bind metering_threshold_control_regs regs_checker i_regs_checker (.clk_sys_i, .resetn_i,
  .avs_address_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .meas_i, .cfg_o,
  .neutral_compare_flag_o, .phase_delay_cycles_o, .temp_sensor_off_o, .interrupt_output_one_o,
  .interrupt_output_two_o);
`default_nettype wire

// [bench/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk_sys_i,
  input wire logic [31:0] rdat_i,
  input wire logic wait_i,
  output logic [9:0] adr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdat_o,
  output logic [3:0] be_o
);
  initial
  begin
    adr_o = 10'h000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdat_o = 32'h00000000;
    be_o = 4'hf;
  end
  // one transfer; held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [7:0] i, input logic [23:0] d,
    output logic [31:0] q);
    @(posedge clk_sys_i);
    rd_o <= !w;
    wr_o <= w;
    adr_o <= {i, 2'b00};
    wdat_o <= {8'h00, d};
    do
    begin
      @(posedge clk_sys_i);
    end
    while (wait_i !== 1'b0);
    q = rdat_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    // released lines do not keep the last value
    adr_o <= ~adr_o;
    wdat_o <= ~wdat_o;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import metering_pkg::*;
  logic clk_sys_i;
  logic resetn_i;
  logic [9:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [3:0] be;
  logic wt;
  meter_inputs_s meas;
  cfg_regs_s cfg;
  logic flag;
  logic tsoff;
  logic interrupt_output_one;
  logic interrupt_output_two;
  logic [11:0] pdly;
  logic [31:0] q;
  logic [23:0] lvl;
  logic [23:0] s;
  logic [23:0] nr;
  logic [23:0] ph;
  logic [23:0] wv [15];
  int n_errors;
  int n_compared;
  int seed = 68;
  logic [7:0] ridx [15] = '{8'h8d, 8'h8e, 8'h8f, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h96,
    8'h97, 8'h98, 8'h9a, 8'h9b, 8'h9d, 8'h9e};
  logic [23:0] rrst [15] = '{24'hffffff, 24'h04ffff, 24'h100009, 24'h0, 24'h0, 24'h0, 24'h0,
    24'h07ff, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
  int rw [15] = '{24, 24, 24, 24, 16, 24, 11, 16, 24, 24, 24, 24, 24, 24, 16};
  logic [23:0] prms [4] = '{24'h008000, 24'h080000, 24'h800000, 24'h800000};

  metering_threshold_control_regs i_metering_threshold_control_regs (.clk_sys_i, .resetn_i,
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .meas_i(meas),
    .cfg_o(cfg), .neutral_compare_flag_o(flag), .phase_delay_cycles_o(pdly),
    .temp_sensor_off_o(tsoff), .interrupt_output_one_o(interrupt_output_one), .interrupt_output_two_o(interrupt_output_two));
  host_model i_host_model (.clk_sys_i, .rdat_i(rdat), .wait_i(wt), .adr_o(adr), .rd_o(rd),
    .wr_o(wr), .wdat_o(wdat), .be_o(be));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] msk(input int w);
    return (32'h1 << w) - 32'h1;
  endfunction
  // expected delay in clocks for one band field
  function automatic logic [31:0] pd(input logic [7:0] f);
    return f[7] ? 32'((f[6:0] > 7'h7d ? 7'h7d : f[6:0]) * 28) : 32'h0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] i, input logic [23:0] d);
    i_host_model.xfer(1'b1, i, d, q);
  endtask
  task automatic rchk(input string nm, input logic [7:0] i, input logic [31:0] e,
    input logic [31:0] m);
    i_host_model.xfer(1'b0, i, 24'h0, q);
    chk(nm, e, q & m);
  endtask
  task automatic chk_all(input logic u);
    for (int k = 0; k < 15; k++)
      rchk("register", ridx[k], (u ? wv[k] : rrst[k]) & msk(rw[k]), 32'hffffffff);
  endtask
  task automatic pulse(input int b, input int n);
    repeat (n)
    begin
      meas[b] <= 1'b1;
      @(posedge clk_sys_i);
      meas[b] <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    test_done();
  end

  initial
  begin
    resetn_i = 1'b0;
    meas = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    chk("temp off", 32'h0, {31'h0, tsoff});
    chk_all(1'b0);
    rchk("soft reset read", 8'h9f, 32'h0, 32'hffffffff);
    rchk("unmapped", 8'h95, 32'h0, 32'hffffffff);
    for (int k = 0; k < 15; k++)
    begin
      wv[k] = 24'($random(seed));
      meas <= meter_inputs_s'($random(seed));
      wreg(ridx[k], wv[k]);
    end
    wreg(8'h9f, 24'h123456);
    chk_all(1'b1);
    wreg(8'h9f, 24'h55aa55);
    chk_all(1'b0);
    for (int k = 0; k < 12; k++)
    begin
      lvl = 24'($random(seed));
      wreg(8'h8d, lvl);
      wreg(8'h98, {19'h0, k[0], 4'h0});
      s = (k < 4) ? lvl - 24'(k[1]) : 24'($random(seed));
      nr = (k < 4) ? s : ~s;
      meas.summed_current_rms <= s;
      meas.neutral_current_rms <= nr;
      repeat (3) @(posedge clk_sys_i);
      chk("compare flag", {31'h0, (k[0] ? nr : s) >= lvl}, {31'h0, flag});
    end
    wreg(8'h94, 24'h008000);
    @(posedge clk_sys_i);
    chk("temp off", 32'h1, {31'h0, tsoff});
    for (int k = 0; k < 4; k++)
    begin
      ph = (k == 3) ? 24'h8385ff : 24'h0585ff;
      wreg(8'h90, ph);
      meas.summed_current_rms <= prms[k];
      meas.neutral_current_rms <= prms[k];
      repeat (4) @(posedge clk_sys_i);
      chk("phase delay", pd(8'(ph >> (8 * (k > 2 ? 2 : k)))), 32'(pdly));
    end
    meas <= '{voltage_magnitude: 12'hfff, default: '0};
    wreg(8'h9f, 24'h5a5a5a);
    chk_all(1'b0);
    wreg(8'h8f, 24'h100002);
    wreg(8'h9a, 24'h000008);
    pulse(2, 2);
    rchk("line energy", 8'h99, 32'h0, 32'h8);
    pulse(2, 1);
    rchk("line energy", 8'h99, 32'h8, 32'h8);
    chk("irq pair", 32'h2, {30'h0, interrupt_output_one, interrupt_output_two});
    wreg(8'h9b, 24'h000008);
    wreg(8'h9a, 24'h000000);
    repeat (2) @(posedge clk_sys_i);
    chk("irq pair", 32'h1, {30'h0, interrupt_output_one, interrupt_output_two});
    wreg(8'h99, 24'h000008);
    repeat (2) @(posedge clk_sys_i);
    chk("irq pair", 32'h0, {30'h0, interrupt_output_one, interrupt_output_two});
    wreg(8'h8e, 24'h02ffff);
    meas.voltage_magnitude <= 12'h0ff;
    @(posedge clk_sys_i);
    pulse(2, 3);
    rchk("sag", 8'h99, 32'h0, 32'h2);
    pulse(2, 1);
    rchk("sag", 8'h99, 32'h2, 32'h2);
    wreg(8'h9f, 24'h55aa55);
    rchk("sag kept", 8'h99, 32'h2, 32'h2);
    wreg(8'h9f, 24'h5a5a5a);
    rchk("sag cleared", 8'h99, 32'h0, 32'h2);
    wreg(8'h8e, 24'h040003);
    pulse(1, 1);
    pulse(0, 3);
    rchk("zero cross timeout", 8'h99, 32'h0, 32'h4);
    pulse(0, 1);
    rchk("zero cross timeout", 8'h99, 32'h4, 32'h4);
    test_done();
  end
endmodule
`default_nettype wire
